// >>> bench/ppd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ppd_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic strobe_n,
    input wire logic download_req,
    input wire logic [7:0] gnd_sense,
    input wire logic ack_n,
    input wire logic ready,
    input wire logic pullup_en,
    input wire logic download_active,
    input wire logic flash_prepared,
    input wire logic flash_next,
    input wire logic byte_valid_to_flash,
    input wire ppd_pkg::ppd_byte_t flash_byte,
    input wire logic attach_lost
);
    import ppd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // pull-ups, session start and ready sources
    property p_pullup; $past(nrst) |-> pullup_en; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up off");
    property p_start;
        $rose(download_active) |-> $past(gnd_sense, 3) == 8'h00 && $past(download_req, 3);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_rdy_src; $rose(ready) |-> $past(flash_prepared) || $past(!ack_n); endproperty
    a_rdy_src: assert property (p_rdy_src) else $error("ready early");
    // byte handover to the flash
    property p_vld_hold;
        byte_valid_to_flash && !flash_next |=> byte_valid_to_flash && $stable(flash_byte);
    endproperty
    a_vld_hold: assert property (p_vld_hold) else $error("byte dropped");
    property p_next_ack;
        byte_valid_to_flash && flash_next |=> !ack_n && !byte_valid_to_flash;
    endproperty
    a_next_ack: assert property (p_next_ack) else $error("no ack");
    // acknowledge held until strobe goes away
    property p_ack_hold; !ack_n && !strobe_n |=> !ack_n; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack short");
    property p_ack_rel; $rose(ack_n) |-> ready; endproperty
    a_ack_rel: assert property (p_ack_rel) else $error("ack release");
    property p_lost; attach_lost |=> !download_active; endproperty
    a_lost: assert property (p_lost) else $error("still active");
    c_ack: cover property ($rose(ack_n));
    c_lost: cover property (attach_lost);
    c_done: cover property ($fell(download_active));
endmodule : ppd_checker
bind ppd_top ppd_checker ppd_checker_i (.clk(clk), .nrst(nrst), .strobe_n(strobe_n),
    .download_req(download_req), .gnd_sense(gnd_sense), .ack_n(ack_n), .ready(ready),
    .pullup_en(pullup_en), .download_active(download_active),
    .flash_prepared(flash_prepared), .flash_next(flash_next),
    .byte_valid_to_flash(byte_valid_to_flash), .flash_byte(flash_byte),
    .attach_lost(attach_lost));
`default_nettype wire

// >>> bench/ppd_pc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppd_pc_model (
    input wire logic clk,
    input wire logic ack_n,
    input wire logic ready,
    output logic strobe_n,
    output logic [7:0] port_data,
    output logic last_byte,
    output logic song_begin_flag,
    output logic download_req,
    output logic [7:0] gnd_sense
);
    // cable unplugged: pull-ups read every line high
    initial begin
        {strobe_n, port_data, last_byte, song_begin_flag, download_req, gnd_sense} = '1;
    end
    // plug or unplug and set the request
    task link(input logic [7:0] g, input logic r);
        @(posedge clk);
        #1 gnd_sense = g;
        download_req = r;
    endtask : link
    // one byte: settle data, strobe, wait ack, release
    task send(input logic [7:0] d, input logic sb, input logic lb);
        int n;
        n = 0;
        @(posedge clk);
        #1 port_data = d;
        song_begin_flag = sb;
        last_byte = lb;
        repeat (4 + $urandom % 4) @(posedge clk);
        #1 strobe_n = 1'b0;
        while (ack_n !== 1'b0 && n < 500) begin
            @(posedge clk);
            #1 n++;
        end
        strobe_n = 1'b1;
        port_data = ~d;
        while (ready !== 1'b1 && n < 900) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : send
endmodule : ppd_pc_model
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ppd_pkg::*;
    logic clk, nrst, flash_prepared, flash_next, stall, lost_seen, vld_q;
    logic strobe_n, last_byte, song_begin_flag, download_req, ack_n, ready, pullup_en;
    logic download_active, byte_valid_to_flash, attach_lost;
    logic [7:0] port_data, gnd_sense, d;
    logic [3:0] st;
    ppd_byte_t flash_byte;
    ppd_byte_t expq[$];
    int fails, n_checks;
    assign st = {ack_n, ready, pullup_en, download_active};
    ppd_top ppd_top_i (.clk(clk), .nrst(nrst), .strobe_n(strobe_n), .port_data(port_data),
        .last_byte(last_byte), .song_begin_flag(song_begin_flag),
        .download_req(download_req), .gnd_sense(gnd_sense), .ack_n(ack_n), .ready(ready),
        .pullup_en(pullup_en), .download_active(download_active),
        .flash_prepared(flash_prepared), .flash_next(flash_next),
        .byte_valid_to_flash(byte_valid_to_flash), .flash_byte(flash_byte),
        .attach_lost(attach_lost));
    ppd_pc_model ppd_pc_model_i (.clk(clk), .ack_n(ack_n), .ready(ready),
        .strobe_n(strobe_n), .port_data(port_data), .last_byte(last_byte),
        .song_begin_flag(song_begin_flag), .download_req(download_req),
        .gnd_sense(gnd_sense));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    // flash side: random pause, then one next pulse; compare each new byte
    always @(posedge clk) begin
        #1;
        flash_next = byte_valid_to_flash && !flash_next && !stall && $urandom % 3 == 0;
        lost_seen = lost_seen | attach_lost;
        if (byte_valid_to_flash && !vld_q) chk(flash_byte, expq.pop_front());
        vld_q = byte_valid_to_flash;
    end
    initial begin
        #20000;
        fails++;
        end_sim();
    end
    initial begin
        void'($urandom(83));
        {nrst, flash_prepared, flash_next, stall, lost_seen, vld_q} = '0;
        fails = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        @(posedge clk);
        #1 chk({6'h0, st}, 10'h00A);
        repeat (10) @(posedge clk);
        #1 chk({6'h0, st}, 10'h00A);
        ppd_pc_model_i.link(8'hFE, 1'b1);
        repeat (10) @(posedge clk);
        #1 chk({6'h0, st}, 10'h00A);
        ppd_pc_model_i.link(8'h00, 1'b1);
        repeat (5) @(posedge clk);
        #1 chk({6'h0, st}, 10'h00B);
        flash_prepared = 1'b1;
        @(posedge clk);
        #1 chk({6'h0, st}, 10'h00F);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            expq.push_back({d, i == 0 || i == 5, i == 7});
            fork
                ppd_pc_model_i.send(d, i == 0 || i == 5, i == 7);
                if (i == 2) begin
                    stall = 1'b1;
                    repeat (20) @(posedge clk);
                    #1 chk({6'h0, st}, 10'h00B);
                    stall = 1'b0;
                end
            join
            chk({6'h0, st}, 10'h00F);
        end
        chk(10'(expq.size()), 10'h000);
        ppd_pc_model_i.link(8'h00, 1'b0);
        repeat (4) @(posedge clk);
        #1 chk({6'h0, st}, 10'h00A);
        ppd_pc_model_i.link(8'h00, 1'b1);
        repeat (6) @(posedge clk);
        #1 chk({6'h0, st}, 10'h00F);
        ppd_pc_model_i.link(8'h01, 1'b1);
        repeat (5) @(posedge clk);
        #1 chk({6'h0, st}, 10'h00A);
        chk({9'h0, lost_seen}, 10'h001);
        end_sim();
    end
endmodule : testbench
`default_nettype wire

// >>> src/ppd_defs.svh
`ifndef PPD_DEFS_SVH
`define PPD_DEFS_SVH

// width of one parallel port data byte
`define PPD_DATA_W 8
// number of ground return lines sensed for attach detection
`define PPD_GND_W 8
// fifo geometry: data byte plus song-begin and last-byte marks
`define PPD_FIFO_W 10
`define PPD_FIFO_D 8
// all ground lines low means a pc is attached
`define PPD_GND_ATTACHED 8'h00
// reset levels of the pc-facing outputs
`define PPD_ACK_N_RST 1'b1
`define PPD_READY_RST 1'b0
// synchroniser reset level for active-low pins pulled up
`define PPD_PIN_HIGH 1'b1

`endif

// >>> src/ppd_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// small synchronous fifo with valid/ready on both sides
module ppd_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;

    // full when pointers differ only in the wrap bit
    wire ptr_same = wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0];
    wire full = ptr_same && (wr_ptr_r[AW] != rd_ptr_r[AW]);
    wire empty = wr_ptr_r == rd_ptr_r;
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr_r[AW-1:0]];

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + (AW + 1)'(push);
            rd_ptr_r <= rd_ptr_r + (AW + 1)'(pop);
        end
    end
endmodule : ppd_fifo

`default_nettype wire

// >>> src/ppd_pkg.sv
package ppd_pkg;

    // handshake states, gray coded along idle-arm-ready-xfer-ack
    typedef enum logic [2:0] {
        PPD_ST_IDLE = 3'h0,
        PPD_ST_ARM = 3'h1,
        PPD_ST_READY = 3'h3,
        PPD_ST_XFER = 3'h2,
        PPD_ST_ACK = 3'h6
    } ppd_state_t;

    // one received byte with its marks
    typedef struct packed {
        logic [7:0] data;
        logic song_begin_flag;
        logic last_byte;
    } ppd_byte_t;

endpackage : ppd_pkg

// >>> src/ppd_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser, one stage pair per bit
module ppd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // first flop feeds only the second
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    meta_r <= RST_VAL[i];
                    sync_r <= RST_VAL[i];
                end else begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate
endmodule : ppd_sync

`default_nettype wire

// >>> src/ppd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppd_defs.svh"

// Functional notes
// - weak pull-ups enabled on all port lines
// - pc attached when all ground lines low
// - ignore port inputs until pc attached
// - acknowledge low: byte taken, ready for next
// - busy line high means ready for download
// - song-begin mark passed with starting byte
// - download activity flagged to other logic
// - byte and marks passed on to flash
// - leave idle on attach plus request
// - arm state waits for flash prepared
// - ready state holds until strobe asserted
// - transfer state asserts valid until next
// - next gives acknowledge, then back to ready
// - request dropped in arm or ready returns machine to idle
module ppd_top (
    input wire logic clk,
    input wire logic nrst,
    // parallel port pins
    input wire logic strobe_n,
    input wire logic [`PPD_DATA_W-1:0] port_data,
    input wire logic last_byte,
    input wire logic song_begin_flag,
    input wire logic download_req,
    input wire logic [`PPD_GND_W-1:0] gnd_sense,
    output logic ack_n,
    output logic ready,
    output logic pullup_en,
    // flash controller and main control
    output logic download_active,
    input wire logic flash_prepared,
    input wire logic flash_next,
    output logic byte_valid_to_flash,
    output ppd_pkg::ppd_byte_t flash_byte,
    output logic attach_lost
);
    import ppd_pkg::*;

    // synchronised pin levels
    logic strobe_n_s;
    logic [`PPD_DATA_W-1:0] data_s;
    logic last_s;
    logic song_s;
    logic req_s;
    logic [`PPD_GND_W-1:0] gnd_s;

    // state and output registers
    ppd_state_t state_r;
    ppd_state_t state_nxt;
    logic ack_n_r;
    logic ready_r;
    logic pullup_en_r;
    logic active_r;
    logic valid_r;
    ppd_byte_t flash_byte_r;
    logic attach_lost_r;

    // fifo handshake wires
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`PPD_FIFO_W-1:0] fifo_out_data;
    ppd_byte_t rx_byte;
    ppd_byte_t head_byte;

    // strobe and the first ground line idle high
    ppd_sync #(
        .W(2),
        .RST_VAL({`PPD_PIN_HIGH, `PPD_PIN_HIGH})
    ) u_sync_hi (
        .clk(clk),
        .nrst(nrst),
        .d({strobe_n, gnd_sense[0]}),
        .q({strobe_n_s, gnd_s[0]})
    );

    // remaining ground lines, same idle level
    ppd_sync #(
        .W(`PPD_GND_W - 1),
        .RST_VAL({(`PPD_GND_W - 1){`PPD_PIN_HIGH}})
    ) u_sync_gnd (
        .clk(clk),
        .nrst(nrst),
        .d(gnd_sense[`PPD_GND_W-1:1]),
        .q(gnd_s[`PPD_GND_W-1:1])
    );

    // data, marks and request; reset low so nothing reads active
    ppd_sync #(
        .W(`PPD_DATA_W + 3),
        .RST_VAL('0)
    ) u_sync_lo (
        .clk(clk),
        .nrst(nrst),
        .d({port_data, last_byte, song_begin_flag, download_req}),
        .q({data_s, last_s, song_s, req_s})
    );

    // attach detection and qualified port inputs
    wire attached = gnd_s == `PPD_GND_ATTACHED;
    wire req_q = attached && req_s;
    wire strobe_q = attached && !strobe_n_s;
    wire released_q = attached && strobe_n_s;

    // byte as presented by the pc with its marks
    assign rx_byte.data = data_s;
    assign rx_byte.song_begin_flag = song_s;
    assign rx_byte.last_byte = last_s;

    // a strobe is taken only when the fifo has room
    wire take_byte = (state_r == PPD_ST_READY) && strobe_q && fifo_in_ready;

    // head of fifo moves to the flash output stage when it is free
    wire load_head = fifo_out_valid && !valid_r;
    assign head_byte = ppd_byte_t'(fifo_out_data);

    // byte store between port and flash side
    ppd_fifo #(
        .W(`PPD_FIFO_W),
        .D(`PPD_FIFO_D)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(take_byte),
        .in_ready(fifo_in_ready),
        .in_data(rx_byte),
        .out_valid(fifo_out_valid),
        .out_ready(!valid_r),
        .out_data(fifo_out_data)
    );

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PPD_ST_IDLE: begin
                if (req_q) begin
                    state_nxt = PPD_ST_ARM;
                end
            end
            PPD_ST_ARM: begin
                if (!req_q) begin
                    state_nxt = PPD_ST_IDLE;
                end else if (flash_prepared) begin
                    state_nxt = PPD_ST_READY;
                end
            end
            PPD_ST_READY: begin
                if (!req_q) begin
                    state_nxt = PPD_ST_IDLE;
                end else if (take_byte) begin
                    state_nxt = PPD_ST_XFER;
                end
            end
            PPD_ST_XFER: begin
                if (!attached) begin
                    state_nxt = PPD_ST_IDLE;
                end else if (flash_next) begin
                    state_nxt = PPD_ST_ACK;
                end
            end
            PPD_ST_ACK: begin
                if (!attached) begin
                    state_nxt = PPD_ST_IDLE;
                end else if (released_q) begin
                    state_nxt = PPD_ST_READY;
                end
            end
            default: begin
                state_nxt = PPD_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= PPD_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pc-facing handshake outputs follow the next state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_n_r <= `PPD_ACK_N_RST;
            ready_r <= `PPD_READY_RST;
        end else begin
            ack_n_r <= state_nxt != PPD_ST_ACK;
            ready_r <= state_nxt == PPD_ST_READY;
        end
    end

    // pull-ups are switched on as soon as reset is released
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pullup_en_r <= 1'b0;
        end else begin
            pullup_en_r <= 1'b1;
        end
    end

    // download activity covers every state but idle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            active_r <= 1'b0;
        end else begin
            active_r <= state_nxt != PPD_ST_IDLE;
        end
    end

    // flash output stage: byte valid from load until next
    always_ff @(posedge clk) begin
        if (!nrst) begin
            valid_r <= 1'b0;
        end else if (load_head) begin
            valid_r <= 1'b1;
        end else if (flash_next || state_r == PPD_ST_IDLE) begin
            valid_r <= 1'b0;
        end
    end

    // data and marks travel unaltered to the flash
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flash_byte_r <= '0;
        end else if (load_head) begin
            flash_byte_r <= head_byte;
        end
    end

    // one-cycle pulse when the pc is unplugged mid-download
    always_ff @(posedge clk) begin
        if (!nrst) begin
            attach_lost_r <= 1'b0;
        end else begin
            attach_lost_r <= (state_r != PPD_ST_IDLE) && !attached;
        end
    end

    // outputs straight from flops
    assign ack_n = ack_n_r;
    assign ready = ready_r;
    assign pullup_en = pullup_en_r;
    assign download_active = active_r;
    assign byte_valid_to_flash = valid_r;
    assign flash_byte = flash_byte_r;
    assign attach_lost = attach_lost_r;

endmodule : ppd_top

`default_nettype wire
